// *** step_sequencer.sv ***
// ten-step speed sequencer with apb register file
//
// Our own choices: the APB register port and the register offsets.
`timescale 1ns/1ns
// offsets and limits; the guard makes a second include harmless
`include "step_seq_regs.svh"
module step_sequencer
  import step_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `SEC_NS / `CLK_NS // clocks per second
) (
  input  wire logic            clk,        // 25 MHz system clock
  input  wire logic            rst_n,      // async reset, active low
  input  wire logic            psel,       // apb select
  input  wire logic            penable,    // apb access phase
  input  wire logic            pwrite,     // apb write
  input  wire logic [11:0]     paddr,      // apb byte address
  input  wire logic [31:0]     pwdata,     // apb write data
  output logic [31:0]          prdata,     // apb read data
  output logic                 pready,     // apb ready
  output logic                 pslverr,    // unmapped address
  input  wire logic [4:0]      din_active, // inputs six..ten, bit 0 = six
  input  wire logic [4:0]      key_level,  // f1..f4, enter held
  input  wire logic [13:0]     ai1_level,  // analog one, 0.01 %
  input  wire logic [13:0]     ai2_level,  // analog two, 0.01 %
  output step_pkg::step_idx_t  step,       // active step, 0 = one
  output step_pkg::drive_cmd_s drive_cmd   // speed and ramp command
);
  import step_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  step_cfg_s   cfg_reg [`STEP_COUNT]; // per-step settings
  logic        run_reg;               // sequencer running
  logic [4:0]  di_role_reg;           // input_function_select per input
  logic [4:0]  key_role_reg;          // function_key_role per key
  logic [4:0]  key_prev_reg;          // last key levels
  step_idx_t   step_reg;              // active step
  step_idx_t   step_next;             // step after this edge
  drive_cmd_s  cmd_reg;               // registered command
  logic [31:0] prdata_reg;            // read data
  logic        pready_reg;            // ready, one cycle
  logic        pslverr_reg;           // error with ready
  elapsed_t    elapsed;               // seconds in step

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic      acc;    // first access cycle
  logic      wr_go;  // write commits here
  logic      is_step;
  logic      is_ctrl;
  logic      is_stat;
  logic      is_role;
  logic      hit;
  step_idx_t a_step;
  logic [1:0] a_word;

  // one wait state: ready rises one cycle into the access phase
  assign acc     = psel & penable & ~pready_reg;
  assign wr_go   = psel & penable & pready_reg & pwrite;
  // step pages sit after the global words; anything else is unmapped
  assign is_step = paddr[11:8] == 4'h0 && paddr[1:0] == 2'h0 &&
                   paddr[7:4] >= `STEP_PAGE_FIRST && paddr[7:4] <= `STEP_PAGE_LAST;
  assign a_step  = paddr[7:4] - `STEP_PAGE_FIRST;
  assign a_word  = paddr[3:2];
  assign is_ctrl = paddr == `CTRL_OFS;
  assign is_stat = paddr == `STAT_OFS;
  assign is_role = paddr == `ROLE_OFS;
  assign hit     = is_step | is_ctrl | is_stat | is_role;

  // ----------------------------------------------------------------
  // field packing and write filtering
  // ----------------------------------------------------------------
  // pack one word of a step for read back
  function automatic logic [31:0] pack_word(step_cfg_s c, logic [1:0] w);
    logic [31:0] d;
    d = 32'h0;
    unique case (w)
      2'h0: begin
        d[`REF_LSB +: 5]  = c.ref_sel;
        d[`DIR_LSB +: 2]  = c.dir;
        d[`RAMP_LSB +: 3] = c.ramp;
        d[`NEXT_LSB +: 5] = c.next_cond;
        d[`JUMP_LSB +: 5] = c.jump_cond;
        d[`TGT_LSB +: 4]  = c.jump_tgt;
      end
      2'h1: d[`FREQ_LSB +: 16] = c.fixed_freq;
      2'h2: begin
        d[`MIN_LSB +: 16] = c.minutes;
        d[`SEC_LSB +: 6]  = c.seconds;
      end
      2'h3: begin
        d[`LOW_LSB +: 14]  = c.low_thr;
        d[`HIGH_LSB +: 14] = c.high_thr;
      end
    endcase
    return d;
  endfunction

  // illegal codes keep the old value; numbers clamp to their range
  function automatic step_cfg_s write_word(step_cfg_s c, logic [1:0] w,
                                           logic [31:0] d);
    step_cfg_s n;
    n = c;
    unique case (w)
      2'h0: begin
        if (d[`REF_LSB +: 5] <= `REF_FIXED) n.ref_sel = d[`REF_LSB +: 5];
        if (d[`DIR_LSB +: 2] <= DIR_REV) n.dir = dir_e'(d[`DIR_LSB +: 2]);
        if (d[`RAMP_LSB +: 3] <= ALTERNATE_RAMP_FOUR) begin
          n.ramp = ramp_e'(d[`RAMP_LSB +: 3]);
        end
        if (d[`NEXT_LSB +: 5] <= COND_F2_T) n.next_cond = cond_e'(d[`NEXT_LSB +: 5]);
        if (d[`JUMP_LSB +: 5] <= COND_F2_T) n.jump_cond = cond_e'(d[`JUMP_LSB +: 5]);
        if (d[`TGT_LSB +: 4] <= `TGT_MAX) n.jump_tgt = d[`TGT_LSB +: 4];
      end
      2'h1: begin
        n.fixed_freq = (d[`FREQ_LSB +: 16] > `FREQ_MAX) ? `FREQ_MAX : d[`FREQ_LSB +: 16];
      end
      2'h2: begin
        n.minutes = d[`MIN_LSB +: 16];
        n.seconds = (d[`SEC_LSB +: 6] > `SEC_MAX) ? `SEC_MAX : d[`SEC_LSB +: 6];
      end
      2'h3: begin
        n.low_thr  = (d[`LOW_LSB +: 14] > `THR_MAX) ? `THR_MAX : d[`LOW_LSB +: 14];
        n.high_thr = (d[`HIGH_LSB +: 14] > `THR_MAX) ? `THR_MAX : d[`HIGH_LSB +: 14];
      end
    endcase
    return n;
  endfunction

  // ----------------------------------------------------------------
  // per-step storage
  // ----------------------------------------------------------------
  // each step owns its own copy of every setting
  for (genvar s = 0; s < `STEP_COUNT; s++) begin : g_step
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        cfg_reg[s] <= CFG_RESET;
      end else if (wr_go && is_step && a_step == step_idx_t'(s)) begin
        cfg_reg[s] <= write_word(cfg_reg[s], a_word, pwdata);
      end
    end
  end

  // ----------------------------------------------------------------
  // global registers
  // ----------------------------------------------------------------
  // run bit and the step change roles of inputs and keys
  // status takes writes without error but keeps nothing: it is read-only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_reg      <= 1'b0;
      di_role_reg  <= 5'h0;
      key_role_reg <= 5'h0;
    end else if (wr_go && is_ctrl) begin
      run_reg <= pwdata[`CTRL_RUN_BIT];
    end else if (wr_go && is_role) begin
      di_role_reg  <= pwdata[`ROLE_DI_LSB +: 5];
      key_role_reg <= pwdata[`ROLE_KEY_LSB +: 5];
    end
  end

  // ----------------------------------------------------------------
  // apb answer
  // ----------------------------------------------------------------
  // read data is captured in the first access cycle, with ready
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0;
    end else begin
      pready_reg  <= acc;
      pslverr_reg <= acc & ~hit;
      if (acc && !pwrite) begin
        prdata_reg <= 32'h0;
        if (is_step) prdata_reg <= pack_word(cfg_reg[a_step], a_word);
        if (is_ctrl) prdata_reg[`CTRL_RUN_BIT] <= run_reg;
        if (is_role) begin
          prdata_reg[`ROLE_DI_LSB +: 5]  <= di_role_reg;
          prdata_reg[`ROLE_KEY_LSB +: 5] <= key_role_reg;
        end
        if (is_stat) begin
          prdata_reg[`STAT_STEP_LSB +: 4]  <= step_reg;
          prdata_reg[`STAT_TIME_LSB +: 22] <= elapsed;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // advance events
  // ----------------------------------------------------------------
  step_cfg_s   cur;      // active step settings
  logic [4:0]  di_ok;    // input active and set to step change
  logic [4:0]  key_hit;  // key press edge and set to step change
  logic        a1_lo;
  logic        a1_hi;
  logic        a2_lo;
  logic        a2_hi;
  elapsed_t    dur;      // step duration in seconds
  logic        expired;
  logic [31:0] evt;      // one bit per condition code
  logic        next_hit;
  logic        jump_hit;

  assign cur     = cfg_reg[step_reg];
  assign di_ok   = din_active & di_role_reg;
  assign key_hit = key_level & ~key_prev_reg & key_role_reg;
  assign a1_lo   = ai1_level < cur.low_thr;
  assign a1_hi   = ai1_level > cur.high_thr;
  assign a2_lo   = ai2_level < cur.low_thr;
  assign a2_hi   = ai2_level > cur.high_thr;
  // worst case 65535 min plus 60 s still fits the 22-bit elapsed count
  assign dur     = elapsed_t'(cur.minutes) * `SEC_PER_MIN + elapsed_t'(cur.seconds);
  assign expired = elapsed >= dur;

  // thresholds compare strictly: a level equal to one never fires
  // bit zero stays low so a disabled condition never fires
  always_comb begin
    evt = 32'h0;
    evt[COND_DI6 +: 5]  = di_ok;
    evt[COND_AI1_LO]    = a1_lo;
    evt[COND_AI1_HI]    = a1_hi;
    evt[COND_AI2_LO]    = a2_lo;
    evt[COND_AI2_HI]    = a2_hi;
    evt[COND_ANALOG_ONE_OUT_OF_WINDOW]  = a1_lo | a1_hi;
    evt[COND_INPUT_TEN_OR_ANALOG_LOW]   = di_ok[4] | a1_lo;
    evt[COND_INPUT_NINE_OR_ANALOG_HIGH] = di_ok[3] | a2_hi;
    evt[COND_F1 +: 5]   = key_hit;
    evt[COND_TIME]      = expired;
    evt[COND_DI6_T +: 5] = di_ok | {5{expired}};
    evt[COND_AI1L_T]    = a1_lo | expired;
    evt[COND_AI2H_T]    = a2_hi | expired;
    evt[COND_F1_T]      = key_hit[0] | expired;
    evt[COND_F2_T]      = key_hit[1] | expired;
  end

  assign next_hit = run_reg & evt[cur.next_cond];
  assign jump_hit = run_reg & evt[cur.jump_cond] & (cur.jump_tgt != 4'h0);

  // ----------------------------------------------------------------
  // step selection
  // ----------------------------------------------------------------
  // jump wins over next; only one move is taken per clock
  // a zero jump target is filtered in jump_hit, so no wrap to 4'hf here
  always_comb begin
    step_next = step_reg;
    if (jump_hit) begin
      step_next = cur.jump_tgt - 4'h1;
    end else if (next_hit) begin
      step_next = (step_reg == `STEP_LAST) ? 4'h0 : step_reg + 4'h1;
    end
  end

  // key history runs while stopped too, so a key held across start is no press
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      step_reg     <= 4'h0;
      key_prev_reg <= 5'h0;
    end else begin
      step_reg     <= step_next;
      key_prev_reg <= key_level;
    end
  end

  // timer is zeroed on every step entry and while stopped
  // clearing on step_next, not step_reg, starts the new step at zero
  step_timer #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_timer (
    .clk    (clk),
    .rst_n  (rst_n),
    .clear  ((step_next != step_reg) | ~run_reg),
    .elapsed(elapsed)
  );

  // ----------------------------------------------------------------
  // drive command
  // ----------------------------------------------------------------
  // follows the active step one clock later
  // registering costs a clock but keeps the decode off the output pins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_reg <= '{`REF_FIXED, 1'b1, `FREQ_RST, DIR_STOP, RAMP_MAIN};
    end else begin
      cmd_reg.ref_sel    <= cur.ref_sel;
      cmd_reg.use_fixed  <= cur.ref_sel == `REF_FIXED;
      cmd_reg.fixed_freq <= cur.fixed_freq;
      cmd_reg.dir        <= cur.dir;
      cmd_reg.ramp       <= cur.ramp;
    end
  end

  assign prdata    = prdata_reg;
  assign pready    = pready_reg;
  assign pslverr   = pslverr_reg;
  assign step      = step_reg;
  assign drive_cmd = cmd_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // the sequences name the two states that five of the twelve properties start from

  sequence s_advance;
    next_hit && !jump_hit;
  endsequence

  sequence s_quiet;
    !jump_hit && run_reg;
  endsequence

  fixed_cmd_a: assert property (1 |=> drive_cmd.fixed_freq == $past(cur.fixed_freq) &&
    drive_cmd.use_fixed == ($past(cur.ref_sel) == `REF_FIXED))
    else $error("fixed frequency command mismatch");
  dir_cmd_a: assert property (1 |=> drive_cmd.dir == $past(cur.dir))
    else $error("direction command mismatch");
  ramp_cmd_a: assert property (1 |=> drive_cmd.ramp == $past(cur.ramp))
    else $error("ramp set mismatch");
  next_step_a: assert property (s_advance |=> step_reg ==
    (($past(step_reg) == `STEP_LAST) ? 4'h0 : $past(step_reg) + 4'h1))
    else $error("step did not advance by one");
  disabled_hold_a: assert property (cur.next_cond == COND_DIS && !jump_hit |=>
    $stable(step_reg)) else $error("disabled condition moved the step");
  input_role_a: assert property (s_quiet and cur.next_cond == COND_DI6 &&
    !di_role_reg[0] |=> $stable(step_reg)) else $error("input without role advanced");
  window_a: assert property (s_quiet and cur.next_cond == COND_ANALOG_ONE_OUT_OF_WINDOW &&
    (ai1_level < cur.low_thr || ai1_level > cur.high_thr) |=> !$stable(step_reg))
    else $error("window miss");
  mixed_ten_a: assert property (s_quiet and cur.next_cond == COND_INPUT_TEN_OR_ANALOG_LOW &&
    di_ok[4] |=> !$stable(step_reg)) else $error("input ten did not advance");
  time_hold_a: assert property (s_quiet and cur.next_cond == COND_TIME && !expired |=>
    $stable(step_reg)) else $error("timed step left early");
  jump_target_a: assert property (jump_hit |=> step_reg == $past(cur.jump_tgt) - 4'h1)
    else $error("jump went to wrong step");
  timer_restart_a: assert property (step_reg != $past(step_reg) |-> elapsed == '0 ##1
    elapsed <= 22'h1) else $error("elapsed time not restarted");
  apb_ready_a: assert property (acc |=> pready ##1 !pready)
    else $error("ready not a single cycle");
endmodule

// *** step_seq_regs.svh ***
// register offsets, field positions, limits and reset values of the step sequencer
`ifndef STEP_SEQ_REGS_SVH
`define STEP_SEQ_REGS_SVH
// Behaviour
// - ten steps, each with own settings
// - fixed source drives step's fixed frequency command
// - step direction stop, forward or reverse
// - minutes count 0 to 65535, default 0
// - seconds 0 to 60 added to minutes
// - step picks one of five ramp sets
// - next condition moves to step plus one
// - disabled condition never leaves the step
// - digital input needs step change role
// - analog low or high threshold crossing
// - analog one outside window advances
// - input ten/analog low, input nine/analog high
// - key press with step change role
// - time condition after minutes plus seconds
// - timed OR event, whichever first
// - jump condition moves to target step
// - jump target step one to ten, or disabled

// ----------------------------------------------------------------
// global registers
// ----------------------------------------------------------------
`define CTRL_OFS        12'h000
`define STAT_OFS        12'h004
`define ROLE_OFS        12'h008
`define CTRL_RUN_BIT    0
`define ROLE_DI_LSB     0
`define ROLE_KEY_LSB    8
`define STAT_STEP_LSB   0
`define STAT_TIME_LSB   8

// ----------------------------------------------------------------
// per-step block: four words at 12'h040 + 16 * step
// ----------------------------------------------------------------
`define STEP_COUNT      10
`define STEP_LAST       4'h9
`define STEP_PAGE_FIRST 4'h4
`define STEP_PAGE_LAST  4'hd
`define REF_LSB         0
`define DIR_LSB         5
`define RAMP_LSB        8
`define NEXT_LSB        12
`define JUMP_LSB        20
`define TGT_LSB         28
`define FREQ_LSB        0
`define MIN_LSB         0
`define SEC_LSB         16
`define LOW_LSB         0
`define HIGH_LSB        16

// ----------------------------------------------------------------
// limits, reset values, timing
// ----------------------------------------------------------------
`define REF_FIXED       5'h10
`define TGT_MAX         4'ha
`define FREQ_MAX        16'h7d00
`define SEC_MAX         6'h3c
`define THR_MAX         14'h2710
`define FREQ_RST        16'h0000
`define MIN_RST         16'h0000
`define SEC_RST         6'h00
`define THR_RST         14'h0000
`define SEC_PER_MIN     22'h00003c
`define SEC_NS          1000000000
`define CLK_NS          40
`endif

// *** step_pkg.sv ***
// types shared by the step sequencer and its timer
package step_pkg;
  `include "step_seq_regs.svh"

  typedef logic [3:0]  step_idx_t;  // 0 = step one
  typedef logic [21:0] elapsed_t;   // seconds in step

  typedef enum logic [1:0] {DIR_STOP, DIR_FWD, DIR_REV} dir_e;

  typedef enum logic [2:0] {
    RAMP_MAIN, ALTERNATE_RAMP_ONE, ALTERNATE_RAMP_TWO,
    ALTERNATE_RAMP_THREE, ALTERNATE_RAMP_FOUR
  } ramp_e;

  // order matters: the event vector is indexed by these codes
  typedef enum logic [4:0] {
    COND_DIS, COND_DI6, COND_DI7, COND_DI8, COND_DI9, COND_DI10,
    COND_AI1_LO, COND_AI1_HI, COND_AI2_LO, COND_AI2_HI,
    COND_ANALOG_ONE_OUT_OF_WINDOW, COND_INPUT_TEN_OR_ANALOG_LOW,
    COND_INPUT_NINE_OR_ANALOG_HIGH,
    COND_F1, COND_F2, COND_F3, COND_F4, COND_ENTER, COND_TIME,
    COND_DI6_T, COND_DI7_T, COND_DI8_T, COND_DI9_T, COND_DI10_T,
    COND_AI1L_T, COND_AI2H_T, COND_F1_T, COND_F2_T
  } cond_e;

  typedef struct packed {
    logic [4:0]  ref_sel;
    dir_e        dir;
    ramp_e       ramp;
    cond_e       next_cond;
    cond_e       jump_cond;
    logic [3:0]  jump_tgt;   // 0 disabled, 1..10
    logic [15:0] fixed_freq; // 0.01 Hz
    logic [15:0] minutes;
    logic [5:0]  seconds;
    logic [13:0] low_thr;    // 0.01 %
    logic [13:0] high_thr;
  } step_cfg_s;

  typedef struct packed {
    logic [4:0]  ref_sel;
    logic        use_fixed;
    logic [15:0] fixed_freq;
    dir_e        dir;
    ramp_e       ramp;
  } drive_cmd_s;

  localparam step_cfg_s CFG_RESET = '{`REF_FIXED, DIR_STOP, RAMP_MAIN, COND_DIS,
    COND_DIS, 4'h0, `FREQ_RST, `MIN_RST, `SEC_RST, `THR_RST, `THR_RST};
endpackage

// *** step_timer.sv ***
// elapsed-seconds counter for the active step
`timescale 1ns/1ns
`include "step_seq_regs.svh"
module step_timer
  import step_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `SEC_NS / `CLK_NS // clocks per second
) (
  input  wire logic          clk,     // system clock
  input  wire logic          rst_n,   // async reset, active low
  input  wire logic          clear,   // hold at zero
  output step_pkg::elapsed_t elapsed  // whole seconds, saturating
);
  import step_pkg::*;

  logic [31:0] pre_reg; // sub-second prescaler
  elapsed_t    sec_reg; // seconds so far

  // ----------------------------------------------------------------
  // counting
  // ----------------------------------------------------------------
  // clear restarts both parts so a new step starts at a whole second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_reg <= 32'h0;
      sec_reg <= '0;
    end else if (clear) begin
      pre_reg <= 32'h0;
      sec_reg <= '0;
    end else if (pre_reg >= TICK_CYCLES - 1) begin
      pre_reg <= 32'h0;
      if (sec_reg != '1) begin // saturate, never wrap
        sec_reg <= sec_reg + 22'h1;
      end
    end else begin
      pre_reg <= pre_reg + 32'h1;
    end
  end

  assign elapsed = sec_reg;
endmodule

// *** step_inputs_model.sv ***
// input-side model: digital inputs, keypad keys and analog levels
`timescale 1ns/1ns
module step_inputs_model (
  input  wire logic   clk,        // system clock
  output logic [4:0]  din_active, // inputs six..ten
  output logic [4:0]  key_level,  // f1..f4, enter
  output logic [13:0] ai1_level,  // analog one, 0.01 %
  output logic [13:0] ai2_level   // analog two, 0.01 %
);
  // quiet start: nothing active, both analog levels mid scale
  initial begin
    din_active = 5'h00;
    key_level  = 5'h00;
    ai1_level  = 14'h1388;
    ai2_level  = 14'h1388;
  end

  // levels change just after an edge, like a synchronised pin
  task automatic set_din(input int i, input logic v);
    @(posedge clk);
    din_active[i] <= v;
  endtask

  // a press is held a few clocks and released, so each press is a new edge
  task automatic press(input int k);
    @(posedge clk);
    key_level[k] <= 1'b1;
    repeat (3) @(posedge clk);
    key_level[k] <= 1'b0;
  endtask

  task automatic set_ai1(input logic [13:0] v);
    @(posedge clk);
    ai1_level <= v;
  endtask
endmodule

// *** step_sequencer_tb.sv ***
// self-checking bench for the step sequencer
`timescale 1ns/1ns
module step_sequencer_tb;
  import step_pkg::*;
  localparam int unsigned TICKS = 10; // short second keeps timed steps brief
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [4:0]  din_active;
  logic [4:0]  key_level;
  logic [13:0] ai1_level;
  logic [13:0] ai2_level;
  step_idx_t   step;
  drive_cmd_s  drive_cmd;
  int          mismatches = 0;
  int          checks_done = 0;
  logic [32:0] exp_q[$];      // expected {pslverr, prdata} per read
  logic [32:0] msk_q[$];      // bits that matter for each read

  always #20 clk = ~clk;

  step_sequencer #(.TICK_CYCLES(TICKS)) step_sequencer_inst (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .din_active(din_active), .key_level(key_level),
    .ai1_level(ai1_level), .ai2_level(ai2_level), .step(step),
    .drive_cmd(drive_cmd));

  step_inputs_model step_inputs_model_inst (
    .clk(clk), .din_active(din_active), .key_level(key_level),
    .ai1_level(ai1_level), .ai2_level(ai2_level));

  // ----------------------------------------------------------------
  // checking helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [32:0] got, input logic [32:0] e, input logic [32:0] m);
    checks_done++;
    if ((got & m) !== (e & m)) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, e);
    end
  endtask

  task automatic stop_test;
    $display("mismatches %0d checks %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // watcher: each completed read takes the oldest note off the queue
  always @(posedge clk) begin
    if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
      chk({pslverr, prdata}, exp_q.pop_front(), msk_q.pop_front());
    end
  end

  // apb master: request held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [32:0] e = 33'h0, input logic [32:0] m = '1);
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    if (!w) begin
      exp_q.push_back(e);
      msk_q.push_back(m);
    end
    @(posedge clk);
    penable <= 1'b1;
    // no cycle count of its own: only the hang guard ends this wait
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // status read, only the step field and the error bit are compared
  task automatic rd_step(input logic [3:0] s);
    apb(1'b0, 12'h004, 32'h0, {29'h0, s}, {1'b1, 32'h0000000f});
  endtask

  function automatic logic [31:0] w0(input dir_e d, input ramp_e r, input cond_e nx,
                                     input cond_e jc, input logic [3:0] t);
    return {t, 3'h0, jc, 3'h0, nx, 1'b0, r, 1'b0, d, 5'h10};
  endfunction

  // hang guard, far beyond the fewer than two hundred clocks the sequence needs
  initial begin
    #80000;
    mismatches++;
    stop_test();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [15:0] f;
    logic [15:0] fc;
    void'($urandom(32'hc469));
    f  = 16'($urandom);
    fc = (f > 16'h7d00) ? 16'h7d00 : f; // frequency clamps at 320.00 Hz
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, 12'h040, 32'h0, 33'h10);
    apb(1'b0, 12'h048, 32'h0, 33'h0);
    apb(1'b0, 12'h3f0, 32'h0, {1'b1, 32'h0});
    apb(1'b1, 12'h040, w0(DIR_FWD, ALTERNATE_RAMP_ONE, COND_DI6, COND_DIS, 4'h0));
    apb(1'b1, 12'h044, {16'h0, f});
    apb(1'b0, 12'h044, 32'h0, {17'h0, fc});
    apb(1'b1, 12'h050, w0(DIR_REV, ALTERNATE_RAMP_FOUR, COND_F1, COND_DIS, 4'h0));
    apb(1'b1, 12'h060, w0(DIR_STOP, RAMP_MAIN, COND_AI1_LO, COND_DIS, 4'h0));
    apb(1'b1, 12'h06c, 32'h00000064);
    apb(1'b1, 12'h070, w0(DIR_STOP, RAMP_MAIN, COND_ANALOG_ONE_OUT_OF_WINDOW, COND_DIS, 4'h0));
    apb(1'b1, 12'h07c, 32'h17700064);
    apb(1'b1, 12'h080, w0(DIR_STOP, RAMP_MAIN, COND_TIME, COND_DIS, 4'h0));
    apb(1'b1, 12'h088, 32'h00020000);
    apb(1'b1, 12'h090, w0(DIR_STOP, RAMP_MAIN, COND_DI10, COND_DI10, 4'h1));
    apb(1'b1, 12'h000, 32'h1);
    repeat (3) @(posedge clk);
    chk({5'h0, drive_cmd}, {5'h0, 5'h10, 1'b1, fc, DIR_FWD, ALTERNATE_RAMP_ONE}, '1);
    // input active but its role not yet set to step change
    step_inputs_model_inst.set_din(0, 1'b1);
    rd_step(4'h0);
    apb(1'b1, 12'h008, 32'h00000111);
    rd_step(4'h1);
    step_inputs_model_inst.set_din(0, 1'b0);
    rd_step(4'h1);
    step_inputs_model_inst.press(0);
    rd_step(4'h2);
    // low level passes step three and the window of step four on successive clocks
    step_inputs_model_inst.set_ai1(14'h0032);
    rd_step(4'h4);
    step_inputs_model_inst.set_ai1(14'h1388);
    rd_step(4'h4);
    repeat (30) @(posedge clk);
    rd_step(4'h5);
    // jump and next both true: the jump target wins
    step_inputs_model_inst.set_din(4, 1'b1);
    rd_step(4'h0);
    step_inputs_model_inst.set_din(4, 1'b0);
    apb(1'b1, 12'h040, w0(DIR_FWD, RAMP_MAIN, COND_DIS, COND_DIS, 4'h0));
    step_inputs_model_inst.set_din(0, 1'b1);
    rd_step(4'h0);
    // input ten alone satisfies the mixed condition while analog one is in range
    apb(1'b1, 12'h040, w0(DIR_FWD, RAMP_MAIN, COND_INPUT_TEN_OR_ANALOG_LOW, COND_DIS, 4'h0));
    step_inputs_model_inst.set_din(4, 1'b1);
    rd_step(4'h1);
    step_inputs_model_inst.set_din(4, 1'b0);
    // zero duration: the timed half of the pair fires with no key pressed
    apb(1'b1, 12'h050, w0(DIR_REV, ALTERNATE_RAMP_FOUR, COND_F1_T, COND_DIS, 4'h0));
    rd_step(4'h2);
    stop_test();
  end
endmodule
